// file: hw/load_logic_byte_multiply_decode.v
// Purpose: decode load, address, multiply, no-op and OR opcodes
// Assumes: one opcode offered per cycle with op_valid from fetch logic
// Notes: registered outputs, one cycle of latency
// Function
// - Opcodes 84-89, 94-97, E8, E9 copy source to destination, no flags.
// - Opcodes 98/99 add a signed offset, 3 bytes, 3/5 cycles, no flags.
// - Opcode F4 multiplies pair halves into the pair, 2 bytes, 8 cycles.
// - Opcode 0F is a no-op of 1 byte and 2 cycles, no flags.
// - Opcodes 42-47 OR source into destination with 2/3 bytes, 3/4 cycles.
// - OR updates zero and sign, clears overflow, keeps the other flags.
`timescale 1ns/100ps
`include "op_decode_consts.vh"
module load_logic_byte_multiply_decode
(
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // From fetch
  input wire op_valid,
  input wire [7:0] opcode,
  // To fetch and execute
  output reg dec_valid,
  output reg dec_known,
  output reg [2:0] op_kind,
  output reg [3:0] dst_mode,
  output reg [3:0] src_mode,
  output reg [2:0] fetch_bytes,
  output reg [3:0] exec_cycles,
  output reg [5:0] flag_update,
  output reg [5:0] flag_value
);

reg known;
reg [2:0] kind;
reg [3:0] dmode;
reg [3:0] smode;
reg [2:0] bytes;
reg [3:0] cycles;
reg [5:0] fupd;
reg [5:0] fval;

// Unknown opcodes decode with zero length so fetch can trap on them
always @*
begin
  known = 1'b1;
  kind = `OPK_NONE;
  dmode = `AM_NONE;
  smode = `AM_NONE;
  bytes = `LEN_NONE;
  cycles = `CYC_NONE;
  fupd = `FLG_NONE;
  fval = `FLG_NONE;
  case (opcode)
    `OPC_XLD_R_ER:
    begin
      kind = `OPK_LOAD;
      dmode = `AM_WR;
      smode = `AM_EXT;
      bytes = `XLD_LEN;
      cycles = `XLD_CYC_R_ER;
    end
    `OPC_XLD_IR_ER:
    begin
      kind = `OPK_LOAD;
      dmode = `AM_IWR;
      smode = `AM_EXT;
      bytes = `XLD_LEN;
      cycles = `XLD_CYC_IR_ER;
    end
    `OPC_XLD_R_IRR:
    begin
      kind = `OPK_LOAD;
      dmode = `AM_REG;
      smode = `AM_IRR;
      bytes = `XLD_LEN;
      cycles = `XLD_CYC_R_IRR;
    end
    `OPC_XLD_IR_IRR:
    begin
      kind = `OPK_LOAD;
      dmode = `AM_IREG;
      smode = `AM_IRR;
      bytes = `XLD_LEN;
      cycles = `XLD_CYC_IR_IRR;
    end
    `OPC_XLD_R_XRR:
    begin
      kind = `OPK_LOAD;
      dmode = `AM_WR;
      smode = `AM_IDX;
      bytes = `XLD_LEN;
      cycles = `XLD_CYC_R_XRR;
    end
    `OPC_XLD_XRR_R:
    begin
      kind = `OPK_LOAD;
      dmode = `AM_IDX;
      smode = `AM_WR;
      bytes = `XLD_LEN;
      cycles = `XLD_CYC_XRR_R;
    end
    `OPC_XLD_ER_R:
    begin
      kind = `OPK_LOAD;
      dmode = `AM_EXT;
      smode = `AM_WR;
      bytes = `XLD_LEN;
      cycles = `XLD_CYC_ER_R;
    end
    `OPC_XLD_ER_IR:
    begin
      kind = `OPK_LOAD;
      dmode = `AM_EXT;
      smode = `AM_IWR;
      bytes = `XLD_LEN;
      cycles = `XLD_CYC_ER_IR;
    end
    `OPC_XLD_IRR_R:
    begin
      kind = `OPK_LOAD;
      dmode = `AM_IRR;
      smode = `AM_REG;
      bytes = `XLD_LEN;
      cycles = `XLD_CYC_IRR_R;
    end
    `OPC_XLD_IRR_IR:
    begin
      kind = `OPK_LOAD;
      dmode = `AM_IRR;
      smode = `AM_IREG;
      bytes = `XLD_LEN;
      cycles = `XLD_CYC_IRR_IR;
    end
    `OPC_XLD_ER_ER:
    begin
      kind = `OPK_LOAD;
      dmode = `AM_EXT;
      smode = `AM_EXT;
      bytes = `XLD_LEN_EXT2;
      cycles = `XLD_CYC_ER_ER;
    end
    `OPC_XLD_ER_IM:
    begin
      kind = `OPK_LOAD;
      dmode = `AM_EXT;
      smode = `AM_IMM;
      bytes = `XLD_LEN_EXT2;
      cycles = `XLD_CYC_ER_IM;
    end
    `OPC_EAC_R:
    begin
      kind = `OPK_EA;
      dmode = `AM_WR;
      smode = `AM_IDX;
      bytes = `EAC_LEN;
      cycles = `EAC_CYC_R;
    end
    `OPC_EAC_RR:
    begin
      kind = `OPK_EA;
      dmode = `AM_WRR;
      smode = `AM_IDX;
      bytes = `EAC_LEN;
      cycles = `EAC_CYC_RR;
    end
    `OPC_MUL:
    begin
      kind = `OPK_MUL;
      dmode = `AM_REGPAIR;
      bytes = `MUL_LEN;
      cycles = `MUL_CYC;
    end
    `OPC_NOP:
    begin
      kind = `OPK_NOP;
      bytes = `NOP_LEN;
      cycles = `NOP_CYC;
    end
    `OPC_OR_R_R, `OPC_OR_R_IR, `OPC_OR_RG_RG,
    `OPC_OR_RG_IRG, `OPC_OR_RG_IM, `OPC_OR_IRG_IM:
    begin
      kind = `OPK_OR;
      fupd = `FLG_OR_EN;
      fval = `FLG_NONE;
      case (opcode[2:0])
        3'h2:
        begin
          dmode = `AM_WR;
          smode = `AM_WR;
          bytes = `OR_LEN_WR;
          cycles = `OR_CYC_DIR;
        end
        3'h3:
        begin
          dmode = `AM_WR;
          smode = `AM_IWR;
          bytes = `OR_LEN_WR;
          cycles = `OR_CYC_IND;
        end
        3'h4:
        begin
          dmode = `AM_REG;
          smode = `AM_REG;
          bytes = `OR_LEN_REG;
          cycles = `OR_CYC_DIR;
        end
        3'h5:
        begin
          dmode = `AM_REG;
          smode = `AM_IREG;
          bytes = `OR_LEN_REG;
          cycles = `OR_CYC_IND;
        end
        3'h6:
        begin
          dmode = `AM_REG;
          smode = `AM_IMM;
          bytes = `OR_LEN_REG;
          cycles = `OR_CYC_DIR;
        end
        default:
        begin
          dmode = `AM_IREG;
          smode = `AM_IMM;
          bytes = `OR_LEN_REG;
          cycles = `OR_CYC_IND;
        end
      endcase
    end
    default:
      known = 1'b0;
  endcase
end

// Registered outputs keep timing off the fetch path
always @(posedge sys_clk)
begin
  if (!rst_n)
  begin
    dec_valid <= 1'b0;
    dec_known <= 1'b0;
    op_kind <= `OPK_NONE;
    dst_mode <= `AM_NONE;
    src_mode <= `AM_NONE;
    fetch_bytes <= `LEN_NONE;
    exec_cycles <= `CYC_NONE;
    flag_update <= `FLG_NONE;
    flag_value <= `FLG_NONE;
  end
  else
  begin
    dec_valid <= op_valid;
    if (op_valid)
    begin
      dec_known <= known;
      op_kind <= kind;
      dst_mode <= dmode;
      src_mode <= smode;
      fetch_bytes <= bytes;
      exec_cycles <= cycles;
      flag_update <= fupd;
      flag_value <= fval;
    end
  end
end

endmodule

// file: hw/op_decode_consts.vh
// Purpose: constants for the opcode decoder
// Assumes: 8-bit opcodes, 4-bit cycle counts
// Notes: addressing mode codes are local to this block
`ifndef OP_DECODE_CONSTS_VH
`define OP_DECODE_CONSTS_VH
// Opcodes
`define OPC_XLD_R_ER 8'h84
`define OPC_XLD_IR_ER 8'h85
`define OPC_XLD_R_IRR 8'h86
`define OPC_XLD_IR_IRR 8'h87
`define OPC_XLD_R_XRR 8'h88
`define OPC_XLD_XRR_R 8'h89
`define OPC_XLD_ER_R 8'h94
`define OPC_XLD_ER_IR 8'h95
`define OPC_XLD_IRR_R 8'h96
`define OPC_XLD_IRR_IR 8'h97
`define OPC_XLD_ER_ER 8'hE8
`define OPC_XLD_ER_IM 8'hE9
`define OPC_EAC_R 8'h98
`define OPC_EAC_RR 8'h99
`define OPC_MUL 8'hF4
`define OPC_NOP 8'h0F
`define OPC_OR_R_R 8'h42
`define OPC_OR_R_IR 8'h43
`define OPC_OR_RG_RG 8'h44
`define OPC_OR_RG_IRG 8'h45
`define OPC_OR_RG_IM 8'h46
`define OPC_OR_IRG_IM 8'h47
// Operation classes
`define OPK_NONE 3'h0
`define OPK_LOAD 3'h1
`define OPK_EA 3'h2
`define OPK_MUL 3'h3
`define OPK_NOP 3'h4
`define OPK_OR 3'h5
// Addressing modes
`define AM_NONE 4'h0
`define AM_WR 4'h1
`define AM_IWR 4'h2
`define AM_REG 4'h3
`define AM_IREG 4'h4
`define AM_EXT 4'h5
`define AM_IRR 4'h6
`define AM_IDX 4'h7
`define AM_IMM 4'h8
`define AM_WRR 4'h9
`define AM_REGPAIR 4'hA
// Flag enable bit positions {c,z,s,v,d,h}
`define FLG_C 5
`define FLG_Z 4
`define FLG_S 3
`define FLG_V 2
`define FLG_D 1
`define FLG_H 0
`define FLG_NONE 6'h00
`define FLG_OR_EN 6'h1C
// Instruction lengths in bytes
`define LEN_NONE 3'h0
`define XLD_LEN 3'h3
`define XLD_LEN_EXT2 3'h4
`define EAC_LEN 3'h3
`define MUL_LEN 3'h2
`define NOP_LEN 3'h1
`define OR_LEN_WR 3'h2
`define OR_LEN_REG 3'h3
// Execution cycle counts
`define CYC_NONE 4'h0
`define XLD_CYC_R_ER 4'h2
`define XLD_CYC_IR_ER 4'h3
`define XLD_CYC_R_IRR 4'h4
`define XLD_CYC_IR_IRR 4'h5
`define XLD_CYC_R_XRR 4'h4
`define XLD_CYC_XRR_R 4'h4
`define XLD_CYC_ER_R 4'h2
`define XLD_CYC_ER_IR 4'h3
`define XLD_CYC_IRR_R 4'h4
`define XLD_CYC_IRR_IR 4'h5
`define XLD_CYC_ER_ER 4'h2
`define XLD_CYC_ER_IM 4'h2
`define EAC_CYC_R 4'h3
`define EAC_CYC_RR 4'h5
`define MUL_CYC 4'h8
`define NOP_CYC 4'h2
`define OR_CYC_DIR 4'h3
`define OR_CYC_IND 4'h4
`endif

// file: sim/decode_assertions.sv
// Purpose: checker for the opcode decoder
// Assumes: answers land one edge after a take
// Notes: watches top ports only
`timescale 1ns/100ps
module decode_assertions
(
  // Clock, reset and request
  input wire sys_clk,
  input wire rst_n,
  input wire op_valid,
  input wire [7:0] opcode,
  // Decode answer
  input wire dec_valid,
  input wire [2:0] op_kind,
  input wire [2:0] fetch_bytes,
  input wire [3:0] exec_cycles,
  input wire [5:0] flag_update,
  input wire [5:0] flag_value
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_take; op_valid |=> dec_valid; endproperty
  a_take: assert property (p_take) else $error("no answer");
  property p_idle; !op_valid |=> !dec_valid; endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  property p_xload;
    op_valid && (opcode inside {[8'h84:8'h89], [8'h94:8'h97], 8'hE8, 8'hE9})
    |=> op_kind == 3'h1 && flag_update == 6'h00;
  endproperty
  a_xload: assert property (p_xload) else $error("load decode");
  property p_eaddr;
    op_valid && opcode == 8'h99 |=> fetch_bytes == 3'h3 && exec_cycles == 4'h5;
  endproperty
  a_eaddr: assert property (p_eaddr) else $error("address decode");
  property p_mul;
    op_valid && opcode == 8'hF4 |=> exec_cycles == 4'h8 && fetch_bytes == 3'h2;
  endproperty
  a_mul: assert property (p_mul) else $error("multiply decode");
  property p_nop;
    op_valid && opcode == 8'h0F |=> fetch_bytes == 3'h1 && exec_cycles == 4'h2;
  endproperty
  a_nop: assert property (p_nop) else $error("no-op decode");
  property p_or;
    op_valid && opcode inside {[8'h42:8'h47]}
    |=> op_kind == 3'h5 && exec_cycles == 4'h3 + {3'h0, $past(opcode[0])};
  endproperty
  a_or: assert property (p_or) else $error("or decode");
  property p_orf;
    dec_valid && op_kind == 3'h5 |-> flag_update == 6'h1C && flag_value == 6'h00;
  endproperty
  a_orf: assert property (p_orf) else $error("or flags");
endmodule

// file: sim/fetch_model.sv
// Purpose: fetch stage stand-in
// Assumes: decoder samples on the rising edge
// Notes: idle byte is inverted so stale data cannot pass
`timescale 1ns/100ps
module fetch_model
(
  // Clock
  input wire sys_clk,
  // To decoder
  output reg op_valid,
  output reg [7:0] opcode
);
  initial
  begin
    op_valid = 1'b0;
    opcode = 8'h00;
  end
  task offer(input [7:0] op);
    @(negedge sys_clk);
    op_valid = 1'b1;
    opcode = op;
    @(negedge sys_clk);
    op_valid = 1'b0;
    opcode = ~op;
  endtask
endmodule

// file: sim/tb.sv
// Purpose: self-checking bench for the opcode decoder
// Assumes: answer one cycle after each offer
// Notes: expectations come from the opcode table
`timescale 1ns/100ps
module tb;
  localparam [95:0] LOPS = 96'h84858687888994959697E8E9;
  localparam [47:0] LCYC = 48'h234544234522;
  // Expected {dst, src} mode pairs for the load and OR forms
  localparam [95:0] LMOD = 96'h152536461771515263645558;
  localparam [47:0] OMOD = 48'h111233343848;
  reg sys_clk;
  reg rst_n;
  wire op_valid, dec_valid, dec_known;
  wire [7:0] opcode;
  wire [2:0] op_kind, fetch_bytes;
  wire [3:0] dst_mode, src_mode, exec_cycles;
  wire [5:0] flag_update, flag_value;
  wire [23:0] got = {dec_valid, dec_known, op_kind, fetch_bytes,
    exec_cycles, flag_update, flag_value};
  integer miscompares, checks_done, i;
  fetch_model fm
  (
    .sys_clk(sys_clk),
    .op_valid(op_valid),
    .opcode(opcode)
  );
  load_logic_byte_multiply_decode dut
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .op_valid(op_valid),
    .opcode(opcode),
    .dec_valid(dec_valid),
    .dec_known(dec_known),
    .op_kind(op_kind),
    .dst_mode(dst_mode),
    .src_mode(src_mode),
    .fetch_bytes(fetch_bytes),
    .exec_cycles(exec_cycles),
    .flag_update(flag_update),
    .flag_value(flag_value)
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task chk(input [7:0] op, input [23:0] seen, input [23:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("Error decode %h expected %h seen %h", op, exp, seen);
    end
  endtask
  task dec(input [7:0] op, input [2:0] k, b, input [3:0] c, input [5:0] f);
    fm.offer(op);
    chk(op, got, {1'b1, |k, k, b, c, f, 6'h00});
  endtask
  task mode(input [7:0] op, input [3:0] d, s);
    fm.offer(op);
    chk(op, {16'h0000, dst_mode, src_mode}, {16'h0000, d, s});
  endtask
  task t_load;
    for (i = 0; i < 12; i = i + 1)
      dec(LOPS[95-8*i -: 8], 3'h1, 3'h3 + (i > 9), LCYC[47-4*i -: 4], 6'h00);
  endtask
  task t_eaddr;
    dec(8'h98, 3'h2, 3'h3, 4'h3, 6'h00);
    dec(8'h99, 3'h2, 3'h3, 4'h5, 6'h00);
  endtask
  task t_mul_nop;
    dec(8'hF4, 3'h3, 3'h2, 4'h8, 6'h00);
    dec(8'h0F, 3'h4, 3'h1, 4'h2, 6'h00);
  endtask
  task t_or;
    for (i = 0; i < 6; i = i + 1)
      dec(8'h42 + i[7:0], 3'h5, 3'h2 + (i > 1), 4'h3 + i[0], 6'h1C);
  endtask
  task t_modes;
    for (i = 0; i < 12; i = i + 1)
      mode(LOPS[95-8*i -: 8], LMOD[95-8*i -: 4], LMOD[91-8*i -: 4]);
    for (i = 0; i < 6; i = i + 1)
      mode(8'h42 + i[7:0], OMOD[47-8*i -: 4], OMOD[43-8*i -: 4]);
    mode(8'h98, 4'h1, 4'h7);
    mode(8'h99, 4'h9, 4'h7);
    mode(8'h0F, 4'h0, 4'h0);
    mode(8'hF4, 4'hA, 4'h0);
    mode(8'hFF, 4'h0, 4'h0);
  endtask
  // Mid-run reset must clear fields left over from a real decode
  task t_reset;
    fm.offer(8'h44);
    rst_n = 1'b0;
    @(negedge sys_clk);
    chk(8'h44, got, 24'h000000);
    chk(8'h44, {16'h0000, dst_mode, src_mode}, 24'h000000);
    rst_n = 1'b1;
    dec(8'h43, 3'h5, 3'h2, 4'h4, 6'h1C);
  endtask
  task t_unknown;
    dec(8'h00, 3'h0, 3'h0, 4'h0, 6'h00);
    dec(8'hFF, 3'h0, 3'h0, 4'h0, 6'h00);
  endtask
  task complete_run;
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    miscompares = 0;
    checks_done = 0;
    rst_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    chk(8'h00, got, 24'h000000);
    rst_n = 1'b1;
    t_load;
    t_eaddr;
    t_mul_nop;
    t_or;
    t_modes;
    t_reset;
    t_unknown;
    complete_run;
  end
endmodule
bind load_logic_byte_multiply_decode decode_assertions watch
(
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .op_valid(op_valid),
  .opcode(opcode),
  .dec_valid(dec_valid),
  .op_kind(op_kind),
  .fetch_bytes(fetch_bytes),
  .exec_cycles(exec_cycles),
  .flag_update(flag_update),
  .flag_value(flag_value)
);
